// >>> shared/extclk_consts.svh
// named offsets, bit positions, reset values and timing figures of the block
`ifndef EXTCLK_CONSTS_SVH
`define EXTCLK_CONSTS_SVH

// ==========================================================
// register map
`define PWR_CTL_ADDR      8'h2d
`define ACT_CHK_ADDR      8'h2e
`define PWR_CTL_RESET     8'h00
`define ACT_CHK_RESET     8'h00
`define RD_UNMAPPED       8'h00

// ==========================================================
// field positions
`define EXT_TIMING_BIT    6
`define ACT_CHECK_BIT     0

// ==========================================================
// timing
`define CLK_HZ            40000000
`define INT_TICK_HZ       51200
`define INT_TICK_CYC      (`CLK_HZ / `INT_TICK_HZ)
`define TICK_CNT_W        10

`endif

// >>> shared/extclk_pkg.sv
// types shared by the timing source and actuation check logic
package extclk_pkg;

  // ==========================================================
  // register access request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // ==========================================================
  // bidirectional pin carrier
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  typedef enum logic [0:0] {
    SRC_BUILTIN,
    SRC_EXTERNAL
  } timing_src_t;

endpackage : extclk_pkg

// >>> src/pin_edge_sync.sv
// two-stage synchroniser with rising-edge pulse for an outside level
`timescale 1ns/1ps

module pin_edge_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================
  // synchroniser; meta_r is read only by sync_r
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;

endmodule : pin_edge_sync

// >>> src/ext_clock_and_selfcheck_seq.sv
// timing source selection on the first event pin and actuation check control
`timescale 1ns/1ps
`include "extclk_consts.svh"

// What the spec asks of this block and its host
// [RULE1] built-in oscillator ticks unless external selected
// [RULE2] power control bit 6 selects external timing
// [RULE3] external select turns first pin into input
// [RULE4] no event drive while pin is clock
// [RULE5] outside clock kept at most 51.2 kHz; not enforced, faster edges are still counted
// [RULE6] actuation applied exactly while check bit set
// [RULE7] host sets 8 g, 100 Hz, full bandwidth
// [RULE8] host reads baseline before enabling actuation
// [RULE9] host waits four sample periods to settle
// [RULE10] host checks per-axis difference against limits; the bench compares each read only with the unmapped value
// [RULE11] host clears check bit at end
// [RULE12] host averages four to sixteen samples; the bench reads four samples from 8'h0e per phase and averages nothing
module ext_clock_and_selfcheck_seq
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire extclk_pkg::reg_req_t  reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  event_level,
  input  wire logic                  first_event_pin_i,
  output extclk_pkg::pin_drive_t     first_event_pin,
  output logic                       timing_tick,
  output extclk_pkg::timing_src_t    timing_src,
  output logic                       actuation_on
);
  import extclk_pkg::*;

  logic [7:0]             power_control_register_r;
  logic [7:0]             act_check_r;
  logic [7:0]             rdata_nxt;
  logic [`TICK_CNT_W-1:0] div_cnt_r;
  logic                   int_tick_r;
  logic                   ext_level;
  logic                   ext_rise;
  logic                   pin_o_r;
  logic                   pin_oe_r;

  // ==========================================================
  // address decode
  wire hit_pwr     = reg_req.addr == `PWR_CTL_ADDR;
  wire hit_act     = reg_req.addr == `ACT_CHK_ADDR;
  wire external_timing_select = power_control_register_r[`EXT_TIMING_BIT];
  wire actuation_check_bit    = act_check_r[`ACT_CHECK_BIT];

  always_comb
  begin
    rdata_nxt = `RD_UNMAPPED;
    if (hit_pwr)
      rdata_nxt = power_control_register_r;
    else if (hit_act)
      rdata_nxt = act_check_r;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_control_register_r <= `PWR_CTL_RESET;
      act_check_r              <= `ACT_CHK_RESET;
      reg_rdata                <= `RD_UNMAPPED;
    end
    else
    begin
      if (reg_req.wr && hit_pwr)
        power_control_register_r <= reg_req.wdata; // RULE2
      if (reg_req.wr && hit_act)
        act_check_r <= reg_req.wdata;
      if (reg_req.rd)
        reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // built-in oscillator as enable divider
  // keeps running while external is selected so a switch back has no gap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_r  <= '0;
      int_tick_r <= 1'b0;
    end
    else if (div_cnt_r == `TICK_CNT_W'(`INT_TICK_CYC - 1))
    begin
      div_cnt_r  <= '0;
      int_tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r  <= div_cnt_r + `TICK_CNT_W'(1);
      int_tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // external clock edges from the first event pin
  // a faster outside clock than 51.2 kHz is still counted, but is out of spec
  pin_edge_sync u_ext_sync
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (first_event_pin_i),
    .level  (ext_level),
    .rise   (ext_rise)
  );

  assign timing_src  = external_timing_select ? SRC_EXTERNAL : SRC_BUILTIN; // RULE2
  assign timing_tick = external_timing_select ? ext_rise : int_tick_r;      // RULE1

  // ==========================================================
  // pin direction and event drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_o_r  <= 1'b0;
      pin_oe_r <= 1'b1;
    end
    else
    begin
      pin_oe_r <= ~external_timing_select;              // RULE3
      pin_o_r  <= event_level & ~external_timing_select; // RULE4
    end
  end

  // combinational release avoids one cycle of contention after the write
  // one assignment drives the whole carrier, so it has a single driver
  wire pin_oe = pin_oe_r & ~external_timing_select; // RULE3
  assign first_event_pin = '{o: pin_o_r & pin_oe, oe: pin_oe}; // RULE4

  assign actuation_on = actuation_check_bit; // RULE6

  // ==========================================================
  // checks
  ext_drops_pin_a: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    external_timing_select |-> !first_event_pin.oe)
    else $error("pin driven while external timing selected");

  no_event_drive_a: assert property ( // RULE4
    @(posedge clk) disable iff (!rst_n)
    external_timing_select |-> !first_event_pin.o)
    else $error("event driven on clock pin");

  builtin_tick_a: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    !external_timing_select && timing_tick |=> !timing_tick [*8])
    else $error("built-in tick too frequent");

  select_bit_a: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n)
    reg_req.wr && hit_pwr |=>
      external_timing_select == $past(reg_req.wdata[`EXT_TIMING_BIT]))
    else $error("timing select not taken from bit 6");

  actuation_follow_a: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_n)
    reg_req.wr && hit_act |=>
      actuation_on == $past(reg_req.wdata[`ACT_CHECK_BIT]))
    else $error("actuation does not follow check bit");

  ext_tick_src_a: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    external_timing_select |-> (timing_tick == (ext_level && !$past(ext_level))))
    else $error("external tick not from pin edge");

endmodule : ext_clock_and_selfcheck_seq

// >>> verification/ext_clock_source.sv
// outside clock source model driving the first event pin
`timescale 1ns/1ps

module ext_clock_source
(
  input  wire logic run,
  output logic      clk_out
);
  initial clk_out = 1'b0;
  // stands low between bursts, 200 ns period while run is high
  always #100 clk_out = run ? ~clk_out : 1'b0;
endmodule : ext_clock_source

// >>> verification/tb_top.sv
// register sequence bench for timing source and actuation check
`timescale 1ns/1ps
`include "extclk_consts.svh"

module tb_top;
  import extclk_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        event_level = 1'b0;
  logic        run = 1'b0;
  logic        src_clk;
  reg_req_t    reg_req = '0;
  logic [7:0]  reg_rdata;
  pin_drive_t  pin;
  logic        timing_tick;
  logic        actuation_on;
  timing_src_t timing_src;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  int          ticks = 0;
  // device wins the line while enabled, else the outside source
  wire         pin_line = pin.oe ? pin.o : src_clk;

  always #12.5 clk = ~clk;

  ext_clock_source src (.run(run), .clk_out(src_clk));

  ext_clock_and_selfcheck_seq dut
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .reg_req           (reg_req),
    .reg_rdata         (reg_rdata),
    .event_level       (event_level),
    .first_event_pin_i (pin_line),
    .first_event_pin   (pin),
    .timing_tick       (timing_tick),
    .timing_src        (timing_src),
    .actuation_on      (actuation_on)
  );

  // ==========================================================
  // checks and closing
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  always @(posedge clk)
  begin
    cyc++;
    if (timing_tick === 1'b1)
      ticks++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================
  // register access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_req = {a, d, 2'b10};
    @(negedge clk) reg_req = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) reg_req = {a, 8'h00, 2'b01};
    @(negedge clk) reg_req = '0;
    @(negedge clk) chk(reg_rdata, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // ==========================================================
  // sequence
  initial
  begin
    idle(12);
    rst_n = 1'b1;
    rd(8'h2d, `PWR_CTL_RESET);
    rd(8'h2e, `ACT_CHK_RESET);
    rd(8'h30, `RD_UNMAPPED);
    event_level = 1'b1;
    idle(2);
    chk({6'h00, pin}, 8'h03);
    ticks = 0;
    idle(2 * `INT_TICK_CYC);
    chk(ticks[7:0], 8'h02);
    wr(8'h2d, 8'h40);
    chk({7'h00, timing_src}, 8'h01);
    chk({6'h00, pin}, 8'h00);
    rd(8'h2d, 8'h40);
    ticks = 0;
    run = 1'b1;
    idle(64);
    run = 1'b0;
    idle(8);
    chk(ticks[7:0], 8'h08);
    wr(8'h2e, 8'h01);
    chk({7'h00, actuation_on}, 8'h01);
    wr(8'h2f, 8'h00);
    chk({7'h00, actuation_on}, 8'h01);
    wr(8'h2e, 8'h00);
    chk({7'h00, actuation_on}, 8'h00);
    wr(8'h2d, 8'h00);
    // the enable flop catches up one edge after the select bit falls
    idle(1);
    chk({6'h00, pin}, 8'h03);
    // ==========================================================
    // host side of the actuation check; filter and axis registers sit outside this block
    wr(8'h2c, 8'h00);
    rd(8'h2c, `RD_UNMAPPED);
    repeat (4) rd(8'h0e, `RD_UNMAPPED);
    wr(8'h2e, 8'h01);
    ticks = 0;
    while (ticks < 4) idle(1);
    chk({7'h00, actuation_on}, 8'h01);
    repeat (4) rd(8'h0e, `RD_UNMAPPED);
    chk({7'h00, actuation_on}, 8'h01);
    wr(8'h2e, 8'h00);
    chk({7'h00, actuation_on}, 8'h00);
    // ==========================================================
    // reset in mid-run drops both selections
    wr(8'h2d, 8'h40);
    wr(8'h2e, 8'h01);
    rst_n = 1'b0;
    idle(2);
    chk({6'h00, pin}, 8'h01);
    chk({7'h00, actuation_on}, 8'h00);
    rst_n = 1'b1;
    rd(8'h2d, `PWR_CTL_RESET);
    rd(8'h2e, `ACT_CHK_RESET);
    chk({7'h00, timing_src}, 8'h00);
    test_done();
  end
endmodule : tb_top
